// File: include/pwr_ctl_pkg.sv
// Package for the power-state and wake controller: states, wake sources, timing counts.
// Assumes a single 250 MHz standby-domain clock.
package pwr_ctl_pkg;
    localparam int CLK_MHZ = 250;
    localparam int HOLD_SEC = 4;
    localparam longint HOLD_CYCLES = longint'(HOLD_SEC) * 64'd1000000 * longint'(CLK_MHZ);
    localparam int DEBOUNCE_US = 10;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
    localparam int NUM_FANS = 3;
    localparam int NUM_WAKE = 9;
    // Wake source bit positions.
    localparam int WK_KBD = 0;
    localparam int WK_SERIAL = 1;
    localparam int WK_USB = 2;
    localparam int WK_LAN = 3;
    localparam int WK_PME = 4;
    localparam int WK_RTC = 5;
    localparam int WK_PCIE = 6;
    localparam int WK_RING = 7;
    localparam int WK_SWITCH = 8;
    // Sources that may wake from suspend to RAM, and from suspend to disk or soft-off.
    localparam logic [8:0] WAKE_OK_S3 = 9'h1ff;
    localparam logic [8:0] WAKE_OK_S45 = 9'h178;
    // Restore policy codes.
    localparam logic [1:0] AC_LAST = 2'h0;
    localparam logic [1:0] AC_ON = 2'h1;
    localparam logic [1:0] AC_OFF = 2'h2;
    localparam logic [7:0] FAN_DUTY_RESET = 8'hff;
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_ON = 4'h2,
        ST_S3 = 4'h4,
        ST_S4 = 4'h8
    } pstate_type;
endpackage

// File: hdl/power_state_wake_control.sv
// Power-state sequencer: power switch, OS commands, wake sources, AC restore, fan gating.
// Assumes all inputs are synchronous to core_clk and the block runs from standby power.
// Notes on behaviour
// - Short switch press: off to on, on to sleep, sleep to on.
// - Long switch press forces soft-off from working or sleeping.
// - Only OS commands, the switch, wake sources and AC return change state.
// - OS may command soft-off.
// - Soft-off drops main rails, standby power stays.
// - After AC return, resume the last state by default.
// - A stored setting selects the AC restore response.
// - Keyboard, serial, USB, ring wake from S3 only; others from S3, S4, S5.
// - LAN and PME wake from soft-off disabled after configuration reset.
// - Setting power-on enables LAN wake from soft-off.
// - A telephony ring is accepted as a wake source.
// - Fans run in the working state.
// - Fans are off in every other state.
// - Each fan channel takes a tachometer input.
// - Each fan channel supports temperature-driven speed or on-off control.
// - A LAN wake packet request powers the system up.
// - PME wakes from S3, S4, S5 only when enabled.
`timescale 1ns/1ps
`default_nettype none
module power_state_wake_control
    import pwr_ctl_pkg::*;
#(
    parameter longint HOLD_CYC = HOLD_CYCLES
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic ac_restored,
    input wire logic last_was_on,
    input wire logic [1:0] ac_policy,
    input wire logic cfg_reset,
    input wire logic cfg_wake_s5_set,
    input wire logic cfg_wake_s5_val,
    input wire logic cfg_pme_en,
    input wire logic switch_pressed,
    input wire logic os_cmd_valid,
    input wire logic [1:0] os_cmd,
    input wire logic [NUM_WAKE-1:0] wake_req,
    input wire logic [NUM_FANS-1:0] fan_tach,
    input wire logic [NUM_FANS-1:0] fan_loop_en,
    input wire logic [7:0] fan_duty,
    output logic main_rails_on,
    output logic [1:0] power_state,
    output logic [NUM_FANS-1:0] fan_drive,
    output logic [NUM_FANS-1:0] fan_tach_pulse
);
    pstate_type state;
    pstate_type next_state;
    logic sw_db;
    logic sw_db_q;
    logic [15:0] db_cnt;
    logic [39:0] hold_cnt;
    logic long_done;
    logic short_rel;
    logic wake_s5_en;
    logic [NUM_WAKE-1:0] wake_mask;
    logic wake_hit;
    logic [7:0] pwm_cnt;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sw_db <= 1'b0;
            db_cnt <= 16'h0000;
        end
        else if (clk_en)
        begin
            if (switch_pressed == sw_db)
                db_cnt <= 16'h0000;
            else if (db_cnt == 16'(DEBOUNCE_CYCLES - 1))
            begin
                sw_db <= switch_pressed;
                db_cnt <= 16'h0000;
            end
            else
                db_cnt <= db_cnt + 16'h0001;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sw_db_q <= 1'b0;
            hold_cnt <= 40'h0;
            long_done <= 1'b0;
        end
        else if (clk_en)
        begin
            sw_db_q <= sw_db;
            if (!sw_db)
            begin
                hold_cnt <= 40'h0;
                long_done <= 1'b0;
            end
            else if (!long_done)
            begin
                hold_cnt <= hold_cnt + 40'h1;
                if (hold_cnt == 40'(HOLD_CYC - 1))
                    long_done <= 1'b1;
            end
        end
    end

    // A release before the threshold ends a short press; a long press acts once at the threshold.
    assign short_rel = sw_db_q && !sw_db && !long_done;

    // soft-off wake enable, cleared by configuration reset
    always_ff @(posedge core_clk)
    begin
        if (rst)
            wake_s5_en <= 1'b0;
        else if (clk_en)
        begin
            if (cfg_reset)
                wake_s5_en <= 1'b0;
            else if (cfg_wake_s5_set)
                wake_s5_en <= cfg_wake_s5_val;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_WAKE; gi++)
        begin : g_wake
            always_comb
            begin
                wake_mask[gi] = 1'b0;
                if (state == ST_S3)
                    wake_mask[gi] = WAKE_OK_S3[gi];
                else if (state == ST_S4 || state == ST_OFF)
                    wake_mask[gi] = WAKE_OK_S45[gi];
                if (gi == WK_PME && !cfg_pme_en)
                    wake_mask[gi] = 1'b0;
                // LAN and PME in soft-off need the soft-off enable
                if ((gi == WK_LAN || gi == WK_PME) && state == ST_OFF && !wake_s5_en)
                    wake_mask[gi] = 1'b0;
            end
        end
    endgenerate

    // masked sources are dropped; ring and LAN count when allowed.
    assign wake_hit = |(wake_req & wake_mask);

    // only switch, OS, wake and AC restore paths change state
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_OFF:
                if (short_rel || wake_hit)
                    next_state = ST_ON;
            ST_ON:
            begin
                if (sw_db && !long_done && hold_cnt == 40'(HOLD_CYC - 1))
                    next_state = ST_OFF;
                else if (short_rel)
                    next_state = ST_S3;
                else if (os_cmd_valid && os_cmd != 2'h0)
                    next_state = (os_cmd == 2'h1) ? ST_S3 : (os_cmd == 2'h2) ? ST_S4 : ST_OFF;
            end
            ST_S3, ST_S4:
            begin
                if (sw_db && !long_done && hold_cnt == 40'(HOLD_CYC - 1))
                    next_state = ST_OFF;
                else if (short_rel || wake_hit)
                    next_state = ST_ON;
            end
        endcase
        // resume after AC return; policy selects
        if (ac_restored)
            next_state = (ac_policy == AC_ON || (ac_policy == AC_LAST && last_was_on)) ? ST_ON : ST_OFF;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            state <= ST_OFF;
        else if (clk_en)
            state <= next_state;
    end

    // rails follow the working state; standby is not gated here
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            main_rails_on <= 1'b0;
            power_state <= 2'h3;
        end
        else if (clk_en)
        begin
            main_rails_on <= (next_state == ST_ON);
            unique case (state)
                ST_ON: power_state <= 2'h0;
                ST_S3: power_state <= 2'h1;
                ST_S4: power_state <= 2'h2;
                ST_OFF: power_state <= 2'h3;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            pwm_cnt <= 8'h00;
        else if (clk_en)
            pwm_cnt <= pwm_cnt + 8'h01;
    end

    generate
        for (gi = 0; gi < NUM_FANS; gi++)
        begin : g_fan
            logic tach_q;
            always_ff @(posedge core_clk)
            begin
                if (rst)
                begin
                    tach_q <= 1'b0;
                    fan_tach_pulse[gi] <= 1'b0;
                end
                else if (clk_en)
                begin
                    tach_q <= fan_tach[gi];
                    fan_tach_pulse[gi] <= fan_tach[gi] && !tach_q;
                end
            end
            // fans on when working; off otherwise; loop duty
            always_ff @(posedge core_clk)
            begin
                if (rst)
                    fan_drive[gi] <= 1'b0;
                else if (clk_en)
                    fan_drive[gi] <= (state == ST_ON) &&
                        (!fan_loop_en[gi] || fan_duty == FAN_DUTY_RESET || pwm_cnt < fan_duty);
            end
        end
    endgenerate

    // Checks.
    sequence s_short_press;
        sw_db_q && !sw_db && !long_done;
    endsequence

    chk_fans_on_work: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && state == ST_ON && !fan_loop_en[0] |=> fan_drive[0] || !clk_en)
        else $error("fan not driven in working state");
    chk_fans_off_sleep: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && state != ST_ON |=> fan_drive == '0 || !clk_en)
        else $error("fan driven outside working state");
    chk_short_off_on: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && !ac_restored && state == ST_OFF) and s_short_press |=> state == ST_ON)
        else $error("short press did not power on");
    chk_short_on_sleep: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && !ac_restored && state == ST_ON && !long_done) and s_short_press |=> state == ST_S3)
        else $error("short press did not sleep");
    chk_long_press_off: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && !ac_restored && state != ST_OFF && sw_db && hold_cnt == 40'(HOLD_CYC - 1) && !long_done
        |=> state == ST_OFF)
        else $error("long press did not force soft-off");
    chk_os_off_rails: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && !ac_restored && state == ST_ON && next_state == ST_OFF |=> !main_rails_on)
        else $error("rails left on after soft-off");
    chk_ignore_wake: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && !ac_restored && state == ST_S4 && !short_rel && !sw_db && (wake_req & WAKE_OK_S45) == '0
        |=> state == ST_S4)
        else $error("disallowed wake changed state");
    chk_pme_gate: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && !ac_restored && !cfg_pme_en && state != ST_ON && !short_rel && !sw_db
        && wake_req == (9'h001 << WK_PME) |=> $stable(state))
        else $error("pme wake while disabled");
    chk_ac_resume: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && ac_restored && ac_policy == AC_LAST |=> state == (last_was_on ? ST_ON : ST_OFF))
        else $error("ac restore did not resume last state");
    chk_cfg_reset_s5: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && cfg_reset |=> !wake_s5_en)
        else $error("soft-off wake enabled after config reset");
endmodule
`default_nettype wire

// File: dv/board_side_model.sv
// Far side model: power switch with contact bounce, wake sources, fan tachometers.
// Assumes the bench calls its tasks and that all changes land on falling edges.
`timescale 1ns/1ps
`default_nettype none
module board_side_model
    import pwr_ctl_pkg::*;
(
    input wire logic core_clk,
    output logic switch_pressed,
    output logic [NUM_WAKE-1:0] wake_req,
    output logic [NUM_FANS-1:0] fan_tach
);
    initial
    begin
        switch_pressed = 1'b0;
        wake_req = '0;
        fan_tach = '0;
    end
    task automatic press(input int len);
        repeat (3)
        begin
            @(negedge core_clk) switch_pressed = 1'b1;
            @(negedge core_clk) switch_pressed = 1'b0;
        end
        @(negedge core_clk) switch_pressed = 1'b1;
        repeat (len) @(negedge core_clk);
        switch_pressed = 1'b0;
        repeat (DEBOUNCE_CYCLES + 20) @(negedge core_clk);
    endtask
    task automatic wake(input int b);
        @(negedge core_clk) wake_req[b] = 1'b1;
        @(negedge core_clk) wake_req[b] = 1'b0;
    endtask
    task automatic spin(input int f);
        @(negedge core_clk) fan_tach[f] = 1'b1;
        @(negedge core_clk) fan_tach[f] = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: dv/power_state_wake_control_tb_top.sv
// Self-checking bench for the power-state and wake controller.
// Assumes a shortened long-press threshold and the partner model in board_side_model.
`timescale 1ns/1ps
`default_nettype none
module power_state_wake_control_tb_top
    import pwr_ctl_pkg::*;
;
    // A debounced press lasts as long as the raw press, so the threshold sits between the two lengths.
    localparam longint HOLD = 4000;
    localparam int SHORT = DEBOUNCE_CYCLES + 20;
    localparam int LONG = DEBOUNCE_CYCLES + 2000;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic ac_restored = 1'b0;
    logic last_was_on = 1'b0;
    logic [1:0] ac_policy = AC_LAST;
    logic cfg_reset = 1'b0;
    logic cfg_wake_s5_set = 1'b0;
    logic cfg_wake_s5_val = 1'b0;
    logic cfg_pme_en = 1'b0;
    logic switch_pressed;
    logic os_cmd_valid = 1'b0;
    logic [1:0] os_cmd = 2'h0;
    logic [NUM_WAKE-1:0] wake_req;
    logic [NUM_FANS-1:0] fan_tach;
    logic [NUM_FANS-1:0] fan_loop_en = '0;
    logic [7:0] fan_duty = 8'hff;
    logic main_rails_on;
    logic [1:0] power_state;
    logic [NUM_FANS-1:0] fan_drive;
    logic [NUM_FANS-1:0] fan_tach_pulse;
    int n_fail = 0;
    int compares = 0;
    int pulses = 0;
    always #2 core_clk = ~core_clk;
    power_state_wake_control #(.HOLD_CYC(HOLD)) uut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .ac_restored(ac_restored), .last_was_on(last_was_on), .ac_policy(ac_policy), .cfg_reset(cfg_reset),
        .cfg_wake_s5_set(cfg_wake_s5_set), .cfg_wake_s5_val(cfg_wake_s5_val), .cfg_pme_en(cfg_pme_en),
        .switch_pressed(switch_pressed), .os_cmd_valid(os_cmd_valid), .os_cmd(os_cmd), .wake_req(wake_req),
        .fan_tach(fan_tach), .fan_loop_en(fan_loop_en), .fan_duty(fan_duty), .main_rails_on(main_rails_on),
        .power_state(power_state), .fan_drive(fan_drive), .fan_tach_pulse(fan_tach_pulse));
    board_side_model far (.core_clk(core_clk), .switch_pressed(switch_pressed), .wake_req(wake_req),
        .fan_tach(fan_tach));
    always @(posedge core_clk) pulses <= pulses + $countones(fan_tach_pulse);
    task automatic check(input logic [1:0] ps, input string msg);
        repeat (4) @(negedge core_clk);
        compares++;
        if (power_state !== ps || main_rails_on !== (ps == 2'h0) || fan_drive !== {NUM_FANS{ps == 2'h0}})
        begin
            n_fail++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge core_clk) s = 1'b1;
        @(negedge core_clk) s = 1'b0;
    endtask
    task automatic os(input logic [1:0] c);
        os_cmd = c;
        pulse(os_cmd_valid);
    endtask
    task automatic t_switch();
        check(2'h3, "reset state");
        far.press(SHORT);
        check(2'h0, "short from off");
        far.press(SHORT);
        check(2'h1, "short from on");
        far.press(SHORT);
        check(2'h0, "short from sleep");
        far.press(LONG);
        check(2'h3, "long from on");
        $display("switch test done");
    endtask
    task automatic t_os();
        os(2'h1);
        check(2'h3, "os cmd in off");
        far.wake(WK_RTC);
        check(2'h0, "rtc from off");
        os(2'h2);
        check(2'h2, "os to disk");
        far.press(LONG);
        check(2'h3, "long from sleep");
        far.wake(WK_SWITCH);
        check(2'h0, "switch wake from off");
        os(2'h3);
        check(2'h3, "os soft off");
        $display("os test done");
    endtask
    task automatic t_table();
        logic ok;
        cfg_pme_en = 1'b1;
        pulse(cfg_reset);
        for (int s = 1; s < 4; s++)
        begin
            for (int b = 0; b < NUM_WAKE; b++)
            begin
                far.wake(WK_RTC);
                os(s[1:0]);
                far.wake(b);
                ok = s == 1 || ((b inside {3, 4, 5, 6, 8}) && (s == 2 || (b inside {5, 6, 8})));
                check(ok ? 2'h0 : s[1:0], "wake table");
                if (!ok)
                    far.wake(WK_RTC);
            end
        end
        $display("wake table test done");
    endtask
    task automatic t_cfg();
        cfg_wake_s5_val = 1'b1;
        pulse(cfg_wake_s5_set);
        os(2'h3);
        far.wake(WK_LAN);
        check(2'h0, "lan from off enabled");
        os(2'h3);
        cfg_pme_en = 1'b0;
        far.wake(WK_PME);
        check(2'h3, "pme disabled");
        cfg_pme_en = 1'b1;
        far.wake(WK_PME);
        check(2'h0, "pme enabled");
        os(2'h1);
        far.wake(WK_RING);
        check(2'h0, "ring from s3");
        os(2'h3);
        pulse(cfg_reset);
        far.wake(WK_LAN);
        check(2'h3, "lan after cfg reset");
        $display("config test done");
    endtask
    task automatic ac(input logic [1:0] p, input logic last, input logic [1:0] ps);
        ac_policy = p;
        last_was_on = last;
        pulse(ac_restored);
        check(ps, "ac restore");
    endtask
    task automatic t_ac();
        int hi = 0;
        ac(AC_LAST, 1'b1, 2'h0);
        ac(AC_LAST, 1'b0, 2'h3);
        ac(AC_ON, 1'b0, 2'h0);
        ac(AC_OFF, 1'b1, 2'h3);
        clk_en = 1'b0;
        far.wake(WK_RTC);
        check(2'h3, "wake while clock enable low");
        clk_en = 1'b1;
        for (int f = 0; f < NUM_FANS; f++)
            far.spin(f);
        repeat (4) @(negedge core_clk);
        compares++;
        if (pulses != NUM_FANS)
        begin
            n_fail++;
            $display("BAD %0t tach pulses %0d", $time, pulses);
        end
        ac(AC_ON, 1'b0, 2'h0);
        fan_loop_en = 3'h1;
        fan_duty = 8'h00;
        repeat (4) @(negedge core_clk);
        compares++;
        if (fan_drive !== 3'h6)
        begin
            n_fail++;
            $display("BAD %0t closed loop did not switch fan off", $time);
        end
        fan_duty = 8'h40;
        repeat (2) @(negedge core_clk);
        repeat (256)
        begin
            @(negedge core_clk);
            if (fan_drive[0] === 1'b1)
                hi++;
        end
        compares++;
        if (hi != 64)
        begin
            n_fail++;
            $display("BAD %0t closed loop on cycles %0d", $time, hi);
        end
        fan_loop_en = '0;
        fan_duty = 8'hff;
        $display("ac and fan test done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #(60000 * 4);
        n_fail++;
        $display("BAD %0t watchdog expired", $time);
        conclude();
    end
    initial
    begin
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        t_switch();
        t_os();
        t_table();
        t_cfg();
        t_ac();
        conclude();
    end
endmodule
`default_nettype wire
